// >>> hdl/cfn_divider.sv
`timescale 1ns/100ps
`include "cfn_defs.svh"

module cfn_divider #(
  parameter int NUM_W = 23
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // request
  input  wire logic             start,
  input  wire logic [NUM_W-1:0] dividend,
  // answer
  output logic                  done,
  output logic      [NUM_W-1:0] quotient
);
  import cfn_pkg::*;

  localparam int DEN_W = 7;
  localparam logic [DEN_W:0] DIVISOR = 8'(`CFN_ENS_CELLS);

  typedef struct packed {
    logic [DEN_W-1:0] rem;
    logic [NUM_W-1:0] quo;
    logic [5:0]       cnt;
    logic             run;
    logic             done;
  } cfn_div_t;

  cfn_div_t s;
  cfn_div_t next_s;
  logic [DEN_W:0] trial;

  // one quotient bit per clock, restoring; NUM_W clocks per division
  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    trial = {s.rem, s.quo[NUM_W-1]};
    if (start)
    begin
      next_s.rem = '0;
      next_s.quo = dividend;
      next_s.cnt = 6'(NUM_W);
      next_s.run = 1'b1;
    end
    else if (s.run)
    begin
      if (trial >= DIVISOR)
      begin
        next_s.rem = DEN_W'(trial - DIVISOR);
        next_s.quo = {s.quo[NUM_W-2:0], 1'b1};
      end
      else
      begin
        next_s.rem = DEN_W'(trial);
        next_s.quo = {s.quo[NUM_W-2:0], 1'b0};
      end
      next_s.cnt = s.cnt - 6'h01;
      if (s.cnt == 6'h01)
      begin
        next_s.run = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign done = s.done;
  assign quotient = s.quo;

endmodule : cfn_divider

// >>> hdl/cfn_noise_threshold.sv
// What this block does
// (RL1) ensemble average: 105 cells summed, divided
// (RL2) ensemble average never below two
// (RL3) untilted estimate: quarter of larger side sum
// (RL4) swath ends drop the outside side sum
// (RL5) tilt lockout: quarter of early sum only
// (RL6) estimate is max with ensemble unless locked
// (RL7) counters cleared, bumped on threshold met
// (RL8) scan processed region; record basic hits
// (RL9) profiles tested only on basic hits
// (RL10) second profile only near range bins
// (RL11) profiles built from sine-squared over range
// (RL12) sine-squared shaping follows canceller response
// (RL13) stop scanning when hits exceed limit
// (RL14) edge filter hit checks outer neighbour
// (RL15) no ground mover on interior filters
// (RL16) counts and profile hits reported out
// (RL17) processor supplies ensemble lockout command
// (RL18) processor supplies clear filter count
// (RL19) quarter divisions done by right shifts; the divide by 105 uses a divider
`timescale 1ns/100ps
`include "cfn_defs.svh"

module cfn_noise_threshold #(
  parameter int MAX_BINS = 68,
  parameter int BIN_W    = 7,
  parameter int MAG_W    = 16,
  parameter int MULT_W   = 8,
  parameter int FRAC_W   = 4,
  parameter int CNT_W    = 11
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // magnitude load from the detector
  input  wire logic                  cellWrite,
  input  wire logic [BIN_W-1:0]      cellBin,
  input  wire logic [3:0]            cellFilter,
  input  wire logic [MAG_W-1:0]      cellMag,
  // commands and multipliers
  input  wire logic                  start,
  input  wire logic [BIN_W-1:0]      rangeBinsPerInterval,
  input  wire logic [4:0]            clearFilterCount,
  input  wire cfn_pkg::cfn_rbi_t     rangeBinInterval,
  input  wire logic                  tiltLockout,
  input  wire logic                  ensembleLockout,
  input  wire logic                  cancellerBypass,
  input  wire logic [MULT_W-1:0]     basicMult,
  input  wire logic [MULT_W-1:0]     edgeClutterMultiplier,
  input  wire logic [CNT_W-1:0]      hitLimit,
  // run status and counts
  output logic                       busy,
  output logic                       done,
  output logic                       capped,
  output logic [MAG_W-1:0]           longEnsembleAvg,
  output logic [CNT_W-1:0]           basicCount,
  output logic [CNT_W-1:0]           profOneCount,
  output logic [CNT_W-1:0]           profTwoCount,
  // hit records
  output logic                       hitValid,
  output logic [BIN_W-1:0]           hitBin,
  output logic [3:0]                 hitFilter,
  output logic [MAG_W-1:0]           hitMag,
  output logic [MAG_W-1:0]           hitNoise,
  output logic                       hitProfOne,
  output logic                       hitProfTwo,
  output logic                       hitGroundMover
);
  import cfn_pkg::*;

  localparam int NFILT = 1 << `CFN_FILT_W;
  localparam int MEM_W = MAX_BINS * NFILT * MAG_W;
  localparam int ACC_W = MAG_W + 7;
  localparam int SUM_W = MAG_W + 2;
  localparam int PW    = MAG_W + 24;

  typedef struct packed {
    cfn_phase_t             phase;
    logic [MEM_W-1:0]       mem;
    logic [BIN_W-1:0]       bin;
    logic [3:0]             filt;
    logic [ACC_W-1:0]       acc;
    logic                   divGo;
    logic [BIN_W-1:0]       nrb;
    logic [3:0]             fLo;
    logic [3:0]             fHi;
    cfn_rbi_t               range_bin_interval;
    logic                   tiltLock;
    logic                   ensLock;
    logic                   bypass;
    logic [MULT_W-1:0]      kBasic;
    logic [MULT_W-1:0]      kEdge;
    logic [CNT_W-1:0]       limit;
    logic                   busy;
    logic                   done;
    logic                   capped;
    logic [MAG_W-1:0]       ensAvg;
    logic [CNT_W-1:0]       cntBasic;
    logic [CNT_W-1:0]       cntOne;
    logic [CNT_W-1:0]       cntTwo;
    logic                   hValid;
    logic [BIN_W-1:0]       hBin;
    logic [3:0]             hFilt;
    logic [MAG_W-1:0]       hMag;
    logic [MAG_W-1:0]       hNoise;
    logic                   hOne;
    logic                   hTwo;
    logic                   hEdge;
  } cfn_state_t;

  cfn_state_t s;
  cfn_state_t next_s;

  // ---------------------------------------------------------------
  // lookups
  // ---------------------------------------------------------------
  function automatic logic [MAG_W-1:0] cellAt(input logic [MEM_W-1:0] m, input logic [BIN_W-1:0] b,
                                              input logic [3:0] f);
    cellAt = m[{b, f} * MAG_W +: MAG_W];
  endfunction : cellAt

  // clutter canceller response folded into the profile numerator
  function automatic logic [14:0] sinSq(input logic [3:0] f);
    logic [3:0] k;
    k = f[3] ? 4'(5'h10 - {1'b0, f}) : f;
    unique case (k)
      4'h0: sinSq = `CFN_SIN_0;
      4'h1: sinSq = `CFN_SIN_1;
      4'h2: sinSq = `CFN_SIN_2;
      4'h3: sinSq = `CFN_SIN_3;
      4'h4: sinSq = `CFN_SIN_4;
      4'h5: sinSq = `CFN_SIN_5;
      4'h6: sinSq = `CFN_SIN_6;
      4'h7: sinSq = `CFN_SIN_7;
      default: sinSq = `CFN_SIN_8;
    endcase
  endfunction : sinSq

  function automatic logic [7:0] r2Of(input cfn_rbi_t r);
    unique case (r)
      RBI_1P0: r2Of = 8'(`CFN_R2_A);
      RBI_1P3: r2Of = 8'(`CFN_R2_B);
      default: r2Of = 8'(`CFN_R2_C);
    endcase
  endfunction : r2Of

  // range term of the first profile; msb flags a bin inside the profile
  function automatic logic [8:0] profOneDen(input logic [BIN_W-1:0] b, input cfn_rbi_t r);
    logic [7:0] k1;
    logic [7:0] ra;
    logic [7:0] k2;
    logic [7:0] rb;
    logic [7:0] rc;
    logic [7:0] r1;
    logic [7:0] i;
    i = 8'(b);
    unique case (r)
      RBI_1P0: {k1, ra, k2, rb, rc, r1} = {8'(`CFN_K1_A), 8'(`CFN_RA_A), 8'(`CFN_K2_A), 8'(`CFN_RB_A),
                                          8'(`CFN_RC_A), 8'(`CFN_R1_A)};
      RBI_1P3: {k1, ra, k2, rb, rc, r1} = {8'(`CFN_K1_B), 8'(`CFN_RA_B), 8'(`CFN_K2_B), 8'(`CFN_RB_B),
                                          8'(`CFN_RC_B), 8'(`CFN_R1_B)};
      default: {k1, ra, k2, rb, rc, r1} = {8'(`CFN_K1_C), 8'(`CFN_RA_C), 8'(`CFN_K2_C), 8'(`CFN_RB_C),
                                          8'(`CFN_RC_C), 8'(`CFN_R1_C)};
    endcase
    if (i <= ra)
      profOneDen = {1'b1, k2};
    else if (i < rb)
      profOneDen = {1'b1, 8'(i + k1)};
    else if (i <= rc)
      profOneDen = {1'b1, rc};
    else if (i <= r1)
      profOneDen = {1'b1, i};
    else
      profOneDen = 9'h000;
  endfunction : profOneDen

  // ---------------------------------------------------------------
  // per-cell estimate and threshold tests
  // ---------------------------------------------------------------
  logic [SUM_W-1:0] early;
  logic [SUM_W-1:0] late;
  logic [MAG_W-1:0] slide;
  logic [MAG_W-1:0] est;
  logic [MAG_W-1:0] mag;
  logic [MAG_W-1:0] outer;
  logic [8:0]       den1;
  logic [7:0]       den2;
  logic             atLo;
  logic             atHi;
  logic             hitBasic;
  logic             hitOne;
  logic             hitTwo;
  logic             hitEdge;
  logic             lastCell;
  logic             divDone;
  logic [ACC_W-1:0] divQuo;

  always_comb
  begin
    early = '0;
    late = '0;
    for (int k = `CFN_WIN_NEAR; k <= `CFN_WIN_FAR; k++)
    begin
      early = early + SUM_W'(cellAt(s.mem, BIN_W'(s.bin - BIN_W'(k)), s.filt));
      late = late + SUM_W'(cellAt(s.mem, BIN_W'(s.bin + BIN_W'(k)), s.filt));
    end
    if (s.bin < BIN_W'(`CFN_EDGE_LO))
      early = '0; // RL4
    if (s.bin > BIN_W'(s.nrb - BIN_W'(`CFN_EDGE_HI_OFF)))
      late = '0; // RL4
    if (s.tiltLock)
      slide = MAG_W'(early >> `CFN_QUARTER_SHIFT); // RL5 RL19
    else
      slide = MAG_W'(((early > late) ? early : late) >> `CFN_QUARTER_SHIFT); // RL3 RL19
    est = (!s.ensLock && s.ensAvg > slide) ? s.ensAvg : slide; // RL6
    mag = cellAt(s.mem, s.bin, s.filt);
    atLo = (s.filt == s.fLo) && (s.filt != 4'h0);
    atHi = (s.filt == s.fHi) && (s.filt != 4'hf);
    outer = cellAt(s.mem, s.bin, atLo ? 4'(s.filt - 4'h1) : 4'(s.filt + 4'h1));
    hitBasic = PW'({mag, FRAC_W'(0)}) >= PW'(est) * PW'(s.kBasic); // RL7
    den1 = profOneDen(s.bin, s.range_bin_interval);
    den2 = 8'(s.bin) + 8'(s.nrb);
    // profiles compared in inverse form to avoid a divider per cell
    hitOne = hitBasic && !s.bypass && den1[8] // RL9 RL11 RL12
             && PW'(mag) * PW'(sinSq(s.filt))
                >= (PW'(est) * PW'(den1[7:0]) * PW'(den1[7:0])) << `CFN_PROF_SHIFT;
    hitTwo = hitBasic && !s.bypass // RL9 RL11
             && 8'(s.bin) <= 8'(r2Of(s.range_bin_interval) - 8'(s.nrb)) // RL10
             && PW'(mag) * PW'(sinSq(s.filt)) >= (PW'(est) * PW'(den2) * PW'(den2)) << `CFN_PROF_SHIFT;
    hitEdge = hitBasic && (atLo || atHi) // RL14 RL15
              && PW'({outer, FRAC_W'(0)}) >= PW'(est) * PW'(s.kEdge);
    lastCell = (s.bin == BIN_W'(s.nrb - BIN_W'(`CFN_REGION_HI_OFF))) && (s.filt == s.fHi);
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.divGo = 1'b0;
    next_s.done = 1'b0;
    next_s.hValid = 1'b0;
    unique case (s.phase)
      IDLE:
      begin
        if (cellWrite && cellBin < BIN_W'(MAX_BINS))
          next_s.mem[{cellBin, cellFilter} * MAG_W +: MAG_W] = cellMag;
        if (start)
        begin
          next_s.phase = ENSUM;
          next_s.nrb = rangeBinsPerInterval;
          next_s.fLo = 4'((5'(`CFN_LO_EDGE_BASE) - clearFilterCount) >> 1); // RL18 RL8
          next_s.fHi = 4'((5'(`CFN_HI_EDGE_BASE) + clearFilterCount) >> 1);
          next_s.range_bin_interval = rangeBinInterval;
          next_s.tiltLock = tiltLockout;
          next_s.ensLock = ensembleLockout; // RL17
          next_s.bypass = cancellerBypass;
          next_s.kBasic = basicMult;
          next_s.kEdge = edgeClutterMultiplier;
          next_s.limit = hitLimit;
          next_s.bin = BIN_W'(rangeBinsPerInterval - BIN_W'(`CFN_ENS_LO_OFF));
          next_s.filt = 4'(`CFN_ENS_F_LO);
          next_s.acc = '0;
          next_s.cntBasic = '0; // RL7
          next_s.cntOne = '0;
          next_s.cntTwo = '0;
          next_s.capped = 1'b0;
          next_s.busy = 1'b1;
        end
      end
      ENSUM:
      begin
        next_s.acc = s.acc + ACC_W'(mag); // RL1
        next_s.filt = 4'(s.filt + 4'h1);
        if (s.filt == 4'(`CFN_ENS_F_HI))
        begin
          next_s.filt = 4'(`CFN_ENS_F_LO);
          next_s.bin = BIN_W'(s.bin + BIN_W'(1));
          if (s.bin == BIN_W'(s.nrb - BIN_W'(`CFN_ENS_HI_OFF)))
          begin
            next_s.phase = ENDIV;
            next_s.divGo = 1'b1;
          end
        end
      end
      ENDIV:
      begin
        if (divDone)
        begin
          next_s.ensAvg = (divQuo < ACC_W'(`CFN_ENS_FLOOR)) ? MAG_W'(`CFN_ENS_FLOOR) : MAG_W'(divQuo); // RL2
          next_s.phase = SCAN;
          next_s.bin = BIN_W'(`CFN_REGION_LO); // RL8
          next_s.filt = s.fLo;
        end
      end
      SCAN:
      begin
        if (hitBasic)
        begin
          next_s.hValid = 1'b1; // RL8 RL16
          next_s.hBin = s.bin;
          next_s.hFilt = s.filt;
          next_s.hMag = mag;
          next_s.hNoise = est;
          next_s.hOne = hitOne;
          next_s.hTwo = hitTwo;
          next_s.hEdge = hitEdge;
          next_s.cntBasic = CNT_W'(s.cntBasic + CNT_W'(1)); // RL7
          next_s.cntOne = CNT_W'(s.cntOne + CNT_W'(hitOne));
          next_s.cntTwo = CNT_W'(s.cntTwo + CNT_W'(hitTwo));
          next_s.capped = (CNT_W'(s.cntBasic + CNT_W'(1)) > s.limit); // RL13
        end
        next_s.filt = 4'(s.filt + 4'h1);
        if (s.filt == s.fHi)
        begin
          next_s.filt = s.fLo;
          next_s.bin = BIN_W'(s.bin + BIN_W'(1));
        end
        if (lastCell || next_s.capped)
        begin
          next_s.phase = IDLE; // RL13
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
        end
      end
    endcase
  end

  cfn_divider #(
    .NUM_W    (ACC_W)
  ) u_div (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (s.divGo),
    .dividend (s.acc),
    .done     (divDone),
    .quotient (divQuo)
  );

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign busy = s.busy;
  assign done = s.done;
  assign capped = s.capped;
  assign longEnsembleAvg = s.ensAvg;
  assign basicCount = s.cntBasic;
  assign profOneCount = s.cntOne;
  assign profTwoCount = s.cntTwo;
  assign hitValid = s.hValid;
  assign hitBin = s.hBin;
  assign hitFilter = s.hFilt;
  assign hitMag = s.hMag;
  assign hitNoise = s.hNoise;
  assign hitProfOne = s.hOne;
  assign hitProfTwo = s.hTwo;
  assign hitGroundMover = s.hEdge;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sRunStart;
    (s.phase == IDLE) && start;
  endsequence

  sequence sEnsDone;
    (s.phase == ENDIV) && busy && s.divGo;
  endsequence

  a_ens_cells: assert property (sRunStart |-> ##105 (s.phase == ENSUM) ##1 sEnsDone) // RL1
    else $error("ensemble walk did not take 105 cells");
  a_ens_floor: assert property (done |-> longEnsembleAvg >= MAG_W'(`CFN_ENS_FLOOR)) // RL2
    else $error("ensemble average below floor");
  a_count_clear: assert property (sRunStart |=> basicCount == '0 && profOneCount == '0 && profTwoCount == '0) // RL7
    else $error("counters not cleared at start");
  a_count_step: assert property (hitValid |-> basicCount == CNT_W'($past(basicCount) + CNT_W'(1))) // RL7
    else $error("basic count did not follow hit");
  a_scan_bounds: assert property (hitValid |-> hitBin >= BIN_W'(`CFN_REGION_LO) // RL8
      && hitBin <= BIN_W'(s.nrb - BIN_W'(`CFN_REGION_HI_OFF)) && hitFilter >= s.fLo && hitFilter <= s.fHi)
    else $error("hit outside processed region");
  a_prof_gate: assert property (profOneCount <= basicCount && profTwoCount <= basicCount) // RL9
    else $error("profile count above basic count");
  a_prof_near: assert property (hitValid && hitProfTwo |-> 8'(hitBin) <= 8'(r2Of(s.range_bin_interval) - 8'(s.nrb))) // RL10
    else $error("second profile hit beyond near range");
  a_bypass_prof: assert property (hitValid && s.bypass |-> !hitProfOne && !hitProfTwo) // RL11
    else $error("profile hit while canceller bypassed");
  a_est_select: assert property (hitValid && !s.ensLock |-> hitNoise >= longEnsembleAvg) // RL6
    else $error("estimate below ensemble average");
  a_edge_only: assert property (hitValid && hitGroundMover |-> hitFilter == s.fLo || hitFilter == s.fHi) // RL15
    else $error("ground mover on interior filter");
  a_cap_stop: assert property ($rose(capped) |-> basicCount > s.limit && done && !busy) // RL13
    else $error("scan capped below limit or kept running");

endmodule : cfn_noise_threshold

// >>> shared/cfn_defs.svh
`ifndef CFN_DEFS_SVH
`define CFN_DEFS_SVH

// ---------------------------------------------------------------
// matrix geometry
// ---------------------------------------------------------------
`define CFN_FILT_W        4
`define CFN_REGION_LO     8
`define CFN_REGION_HI_OFF 7
`define CFN_EDGE_LO       13
`define CFN_EDGE_HI_OFF   14
`define CFN_WIN_NEAR      2
`define CFN_WIN_FAR       5
`define CFN_QUARTER_SHIFT 2
`define CFN_LO_EDGE_BASE  17
`define CFN_HI_EDGE_BASE  15

// ---------------------------------------------------------------
// long ensemble average
// ---------------------------------------------------------------
`define CFN_ENS_LO_OFF 21
`define CFN_ENS_HI_OFF 7
`define CFN_ENS_F_LO   5
`define CFN_ENS_F_HI   11
`define CFN_ENS_CELLS  105
`define CFN_ENS_FLOOR  2

// ---------------------------------------------------------------
// profile shaping: 1440*sin^2(pi*j/16), scaled by 16
// ---------------------------------------------------------------
`define CFN_PROF_SHIFT 4
`define CFN_SIN_0 15'h0000
`define CFN_SIN_1 15'h036d
`define CFN_SIN_2 15'h0d2e
`define CFN_SIN_3 15'h1bc7
`define CFN_SIN_4 15'h2d00
`define CFN_SIN_5 15'h3e39
`define CFN_SIN_6 15'h4cd2
`define CFN_SIN_7 15'h5693
`define CFN_SIN_8 15'h5a00

// ---------------------------------------------------------------
// profile break points per range-bin interval (1.0 / 1.3 / 1.6 us)
// ---------------------------------------------------------------
`define CFN_K1_A 8
`define CFN_K1_B 6
`define CFN_K1_C 5
`define CFN_RA_A 18
`define CFN_RA_B 14
`define CFN_RA_C 11
`define CFN_K2_A 26
`define CFN_K2_B 20
`define CFN_K2_C 11
`define CFN_RB_A 29
`define CFN_RB_B 22
`define CFN_RB_C 16
`define CFN_RC_A 37
`define CFN_RC_B 28
`define CFN_RC_C 18
`define CFN_R1_A 61
`define CFN_R1_B 23
`define CFN_R1_C 50
`define CFN_R2_A 124
`define CFN_R2_B 95
`define CFN_R2_C 78

`endif

// >>> shared/cfn_pkg.sv
package cfn_pkg;

  typedef enum logic [1:0] {
    RBI_1P0,
    RBI_1P3,
    RBI_1P6
  } cfn_rbi_t;

  typedef enum logic [1:0] {
    IDLE,
    ENSUM,
    ENDIV,
    SCAN
  } cfn_phase_t;

endpackage : cfn_pkg

// >>> testbench/cfn_processor_model.sv
`timescale 1ns/100ps

module cfn_processor_model (
  // clock
  input  wire logic        clk,
  // load request
  input  wire logic        go,
  input  wire logic [1:0]  pattern,
  output logic             loaded,
  // magnitude stream
  output logic             cellWrite,
  output logic [6:0]       cellBin,
  output logic [3:0]       cellFilter,
  output logic [15:0]      cellMag
);
  logic [15:0] mag [0:67][0:15];

  initial
  begin
    {loaded, cellWrite, cellBin, cellFilter, cellMag} = '0;
    forever
    begin
      @(posedge clk);
      if (go)
      begin
        loaded = 1'b0;
        #1;
        for (int b = 0; b < 68; b++)
          for (int f = 0; f < 16; f++)
          begin
            mag[b][f] = (pattern == 2'h0) ? 16'h0020 : (pattern == 2'h1) ? 16'h0000 : 16'((b * b + 3 * f) % 97);
            {cellWrite, cellBin, cellFilter, cellMag} = {1'b1, 7'(b), 4'(f), mag[b][f]};
            @(posedge clk);
            #1;
          end
        // released bus shows a changed value so a stale sample cannot pass
        cellWrite = 1'b0;
        cellMag   = ~cellMag;
        loaded    = 1'b1;
      end
    end
  end
endmodule : cfn_processor_model

// >>> testbench/testbench.sv
`timescale 1ns/100ps
`include "cfn_defs.svh"

module testbench;
  import cfn_pkg::*;
  logic        clk, rst_n, start, go, loaded, cellWrite, tiltLockout, ensembleLockout, cancellerBypass;
  logic        busy, done, capped, hitValid, hitProfOne, hitProfTwo, hitGroundMover;
  logic [1:0]  pattern;
  logic [3:0]  cellFilter, hitFilter;
  logic [4:0]  clearFilterCount;
  logic [6:0]  cellBin, rangeBinsPerInterval, hitBin;
  logic [7:0]  basicMult, edgeClutterMultiplier;
  logic [10:0] hitLimit, basicCount, profOneCount, profTwoCount;
  logic [15:0] cellMag, longEnsembleAvg, hitMag, hitNoise;
  cfn_rbi_t    rangeBinInterval;
  int          miscompares, checked, cycles, hits, profOneHits, profTwoHits, ens, lo, hi, lim2;
  int          k1[3] = '{`CFN_K1_A, `CFN_K1_B, `CFN_K1_C}, ra[3] = '{`CFN_RA_A, `CFN_RA_B, `CFN_RA_C};
  int          k2[3] = '{`CFN_K2_A, `CFN_K2_B, `CFN_K2_C}, rb[3] = '{`CFN_RB_A, `CFN_RB_B, `CFN_RB_C};
  int          rc[3] = '{`CFN_RC_A, `CFN_RC_B, `CFN_RC_C}, r1[3] = '{`CFN_R1_A, `CFN_R1_B, `CFN_R1_C};

  cfn_noise_threshold cfn_noise_threshold_i (.clk, .rst_n, .cellWrite, .cellBin, .cellFilter, .cellMag, .start,
    .rangeBinsPerInterval, .clearFilterCount, .rangeBinInterval, .tiltLockout, .ensembleLockout, .cancellerBypass,
    .basicMult, .edgeClutterMultiplier, .hitLimit, .busy, .done, .capped, .longEnsembleAvg, .basicCount,
    .profOneCount, .profTwoCount, .hitValid, .hitBin, .hitFilter, .hitMag, .hitNoise, .hitProfOne, .hitProfTwo,
    .hitGroundMover);

  cfn_processor_model cfn_processor_model_i (.clk, .go, .pattern, .loaded, .cellWrite, .cellBin, .cellFilter,
    .cellMag);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // reference model
  // ----------------------------------------
  function automatic int m(int b, int f);
    return int'(cfn_processor_model_i.mag[b][f]);
  endfunction : m

  function automatic int est(int i, int j);
    int e = 0;
    int l = 0;
    int s;
    for (int k = 2; k < 6; k++)
    begin
      if (i >= 13) e += m(i - k, j);
      if (i <= rangeBinsPerInterval - 14) l += m(i + k, j);
    end
    s = tiltLockout ? e / 4 : ((e > l) ? e : l) / 4;
    return (!ensembleLockout && ens > s) ? ens : s;
  endfunction : est

  function automatic bit isHit(int i, int j);
    return m(i, j) * 16 >= est(i, j) * basicMult;
  endfunction : isHit

  function automatic bit gm(int i, int j);
    if (j == lo && lo > 0) return m(i, j - 1) * 16 >= est(i, j) * edgeClutterMultiplier;
    if (j == hi && hi < 15) return m(i, j + 1) * 16 >= est(i, j) * edgeClutterMultiplier;
    return 1'b0;
  endfunction : gm

  // first profile range term; zero marks a bin beyond the profile
  function automatic int d1(int i);
    int r;
    r = int'(rangeBinInterval);
    if (i <= ra[r]) return k2[r];
    if (i < rb[r]) return i + k1[r];
    if (i <= rc[r]) return rc[r];
    return (i <= r1[r]) ? i : 0;
  endfunction : d1

  // profile hit in inverse form: mag * 1440 sin^2 >= est * d^2, both sides scaled by 16
  function automatic bit prof(int i, int j, int d);
    real s;
    s = $sin(3.14159265358979 * j / 16.0);
    return d > 0 && !cancellerBypass && m(i, j) * int'(23040.0 * s * s) >= est(i, j) * d * d * 16;
  endfunction : prof

  function automatic int expCount();
    int n = 0;
    for (int i = 8; i <= rangeBinsPerInterval - 7; i++)
      for (int j = lo; j <= hi; j++)
        if (isHit(i, j) && n <= hitLimit) n++;
    return n;
  endfunction : expCount

  // ----------------------------------------
  // checking and stimulus
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    checked++;
    if (seen !== expected)
    begin
      miscompares++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, expected);
    end
  endtask : check

  task give_verdict;
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      give_verdict;
    end
  end

  // hit fields are looked at mid-cycle, where they have settled
  always @(negedge clk)
    if (hitValid === 1'b1)
    begin
      hits++;
      profOneHits += int'(hitProfOne);
      profTwoHits += int'(hitProfTwo);
      check(hitNoise, est(hitBin, hitFilter));
      check(hitMag, m(hitBin, hitFilter));
      check(isHit(hitBin, hitFilter), 1);
      check(hitGroundMover, gm(hitBin, hitFilter));
      check(hitProfTwo && hitBin > lim2, 0);
      check((hitProfOne || hitProfTwo) && cancellerBypass, 0);
      check(hitProfOne, prof(hitBin, hitFilter, d1(hitBin)));
      check(hitProfTwo, prof(hitBin, hitFilter, (hitBin <= lim2) ? hitBin + rangeBinsPerInterval : 0));
    end

  task automatic load(input logic [1:0] p);
    pattern = p;
    go = 1'b1;
    tick;
    go = 1'b0;
    repeat (1200)
    begin
      @(posedge clk);
      if (loaded) break;
    end
    #1;
  endtask : load

  task automatic run(input int nrb, nf, input cfn_rbi_t range_bin_interval, input logic tl, el, cb, input int bm, em, lim);
    int n;
    rangeBinsPerInterval = 7'(nrb);
    clearFilterCount = 5'(nf);
    rangeBinInterval = range_bin_interval;
    tiltLockout = tl;
    ensembleLockout = el;
    cancellerBypass = cb;
    basicMult = 8'(bm);
    edgeClutterMultiplier = 8'(em);
    hitLimit = 11'(lim);
    lo = (17 - nf) / 2;
    hi = (15 + nf) / 2;
    lim2 = ((range_bin_interval == RBI_1P0) ? `CFN_R2_A : (range_bin_interval == RBI_1P3) ? `CFN_R2_B : `CFN_R2_C) - nrb;
    ens = 0;
    for (int b = nrb - 21; b <= nrb - 7; b++)
      for (int f = 5; f <= 11; f++)
        ens += m(b, f);
    ens = ens / 105;
    if (ens < 2) ens = 2;
    n = expCount();
    hits = 0;
    profOneHits = 0;
    profTwoHits = 0;
    start = 1'b1;
    tick;
    start = 1'b0;
    repeat (4000)
    begin
      @(negedge clk);
      if (done === 1'b1) break;
    end
    tick;
    check(busy, 0);
    check(longEnsembleAvg, ens);
    check(basicCount, n);
    check(capped, n > lim);
    check(hits, n);
    check(profOneCount, profOneHits);
    check(profTwoCount, profTwoHits);
  endtask : run

  initial
  begin
    {rst_n, start, go, pattern, tiltLockout, ensembleLockout, cancellerBypass} = '0;
    {rangeBinsPerInterval, clearFilterCount, basicMult, edgeClutterMultiplier, hitLimit} = '0;
    rangeBinInterval = RBI_1P0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    check(busy, 0);
    check(basicCount, 0);
    load(2'h0);
    run(64, 7, RBI_1P0, 1'b0, 1'b0, 1'b1, 16, 16, 2047);
    run(64, 7, RBI_1P0, 1'b0, 1'b0, 1'b1, 16, 16, 10);
    load(2'h1);
    run(64, 7, RBI_1P0, 1'b0, 1'b0, 1'b1, 16, 16, 2047);
    run(64, 7, RBI_1P0, 1'b0, 1'b1, 1'b1, 16, 16, 2047);
    load(2'h2);
    run(68, 13, RBI_1P6, 1'b0, 1'b0, 1'b0, 24, 20, 2047);
    run(68, 13, RBI_1P6, 1'b1, 1'b0, 1'b0, 24, 20, 2047);
    run(68, 13, RBI_1P0, 1'b0, 1'b0, 1'b0, 24, 20, 2047);
    run(66, 15, RBI_1P3, 1'b0, 1'b1, 1'b0, 20, 16, 2047);
    give_verdict;
  end
endmodule : testbench
